// ### hw/iseq_pkg.sv
// shared constants and types of the i2c status event sequencer
package iseq_pkg;

	// =====================================================================
	// register port
	localparam int ISEQ_AW = 3;
	localparam int ISEQ_DW = 8;
	localparam logic [2:0] OFS_STATUS = 3'h0;
	localparam logic [2:0] OFS_CTRL = 3'h1;
	localparam logic [2:0] OFS_DATA = 3'h2;
	localparam logic [2:0] OFS_IRQ = 3'h3;
	localparam logic [2:0] OFS_MASK = 3'h4;

	// =====================================================================
	// bus_control_reg fields; start, stop and release are command strobes
	localparam int CTL_ENABLE = 0;
	localparam int CTL_WAIT_SEL = 1;
	localparam int CTL_STOP_IE = 2;
	localparam int CTL_ACK_EN = 3;
	localparam int CTL_START = 4;
	localparam int CTL_STOP = 5;
	localparam int CTL_WREL = 6;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// =====================================================================
	// bus_status_reg fields
	localparam int ST_MSTS = 7;
	localparam int ST_ALD = 6;
	localparam int ST_EXC = 5;
	localparam int ST_COI = 4;
	localparam int ST_TRC = 3;
	localparam int ST_ACKD = 2;
	localparam int ST_STD = 1;
	localparam int ST_SPD = 0;

	// =====================================================================
	// interrupt status and mask bits
	localparam int IRQ_BYTE = 0;
	localparam int IRQ_STOP = 1;
	localparam int IRQ_W = 2;

	// =====================================================================
	// serial clock positions
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_EXC = 4'h3;
	localparam logic [3:0] BIT_RW = 4'h7;
	localparam logic [3:0] BIT_PT8 = 4'h8;
	localparam logic [3:0] BIT_PT9 = 4'h9;
	localparam logic [3:0] EXC_LO = 4'h0;
	localparam logic [3:0] EXC_HI = 4'hf;

	// =====================================================================
	// timing: half serial clock period, least time so rounded up
	localparam int T_HALF_NS = 5000;
	localparam int CLK_MHZ = 250;
	localparam int HALF_CYC_DEF = (T_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 16;

	// =====================================================================
	// status snapshots, don't-care positions masked out
	localparam logic [7:0] MASK_X = 8'hf7;
	localparam logic [7:0] MASK_XX = 8'hf3;
	localparam logic [7:0] MASK_ALL = 8'hff;
	localparam logic [7:0] SNAP_EXT_ADDR = 8'ha6;
	localparam logic [7:0] SNAP_EXT_DATA = 8'ha0;
	localparam logic [7:0] SNAP_LOSS8 = 8'h40;
	localparam logic [7:0] SNAP_LOSS9 = 8'h44;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} iseq_bus_req_t;

	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
	} iseq_pins_t;

	typedef enum logic [2:0] {
		M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_HIGH
	} iseq_mstate_t;

endpackage

// ### hw/iseq_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module iseq_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// level
	input wire logic din,
	output logic dout
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_dout;

	// idle bus lines are high, so all three stages and output reset high
	always_comb begin
		next_stage = {stage[1:0], din};
		next_dout = (stage[2] == stage[1]) ? stage[1] : dout;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stage <= 3'h7;
			dout <= 1'b1;
		end else begin
			stage <= next_stage;
			dout <= next_dout;
		end
	end
endmodule

// ### hw/iseq_cond.sv
// start, stop and serial clock edge detector on filtered lines
`timescale 1ns/100ps
module iseq_cond (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// filtered lines
	input wire logic scl,
	input wire logic sda,
	// one-cycle pulses
	output logic start_ev,
	output logic stop_ev,
	output logic rise_ev,
	output logic fall_ev
);
	logic scl_q;
	logic sda_q;

	assign rise_ev = scl & ~scl_q;
	assign fall_ev = ~scl & scl_q;
	assign start_ev = scl & scl_q & sda_q & ~sda;
	assign stop_ev = scl & scl_q & ~sda_q & sda;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
endmodule

// ### hw/iseq_top.sv
// i2c channel: bus events, status snapshot, interrupt and master engine
`timescale 1ns/100ps
// Operation
// - as master sending an extension code, interrupt after the address with status 1010X110.
// - master data after extension code, 8-clock wait: interrupt per byte with status 1010X000.
// - master data after extension code, 9-clock wait: interrupt per byte with status 1010X100.
// - after the final extension-code data byte, before stop, status reads 1010XX00.
// - a detected stop interrupts only with the stop interrupt enable set, status 00000001.
// - traffic that does not involve the device raises no interrupt but the enabled stop one.
// - arbitration lost in an extension code, continuing as slave, first shows 0110X010.
// - as slave after such a loss with 8-clock wait, each data byte shows 0010X000.
// - as slave after such a loss with 9-clock wait, shows 0010X110, 0010X100, 0010XX00.
// - loss in data with 8-clock wait shows 10001110, then 01000000, then no further part.
// - loss in data with 9-clock wait shows 01000100 at the loss, after 10001110.
// - loss by a foreign stop shows 1000X110 after address, then 01000001 at the enabled stop.
// - a stop request generates a stop, and a stop seen on the bus sets the stop flag.
// - wait select puts data events on clock 8 or 9; a master's address event is on clock 9.
module iseq_top #(
	parameter int HALF_CYC = iseq_pkg::HALF_CYC_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// register port
	input wire iseq_pkg::iseq_bus_req_t bus_req,
	output logic [iseq_pkg::ISEQ_DW-1:0] rd_data,
	// interrupt
	output logic bus_event_irq,
	// open-drain lines
	input wire logic scl_in,
	input wire logic data_line_pin,
	output iseq_pkg::iseq_pins_t pins
);
	import iseq_pkg::*;

	localparam logic [CNT_W-1:0] HALF_W = CNT_W'(HALF_CYC);
	localparam logic [CNT_W-1:0] MID_W = CNT_W'(HALF_CYC / 2);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic scl_line, sda_line, start_ev, stop_ev, rise_ev, fall_ev;

	// =====================================================================
	// line conditioning
	iseq_sync u_sync_scl (.clk_sys(clk_sys), .srst(srst), .din(scl_in),
		.dout(scl_line));
	iseq_sync u_sync_sda (.clk_sys(clk_sys), .srst(srst),
		.din(data_line_pin), .dout(sda_line));
	iseq_cond u_cond (.clk_sys(clk_sys), .srst(srst), .scl(scl_line),
		.sda(sda_line), .start_ev(start_ev), .stop_ev(stop_ev),
		.rise_ev(rise_ev), .fall_ev(fall_ev));

	// =====================================================================
	// register state and decode
	logic [3:0] ctrl, next_ctrl;
	logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic [7:0] tx_byte, next_tx_byte, next_rd_data;
	logic next_irq;
	logic wr_ctrl, wr_data, start_cmd, stop_cmd, wrel_cmd, rd_status;
	logic enable, wait_sel, stop_ie, ack_en;

	assign enable = ctrl[CTL_ENABLE];
	assign wait_sel = ctrl[CTL_WAIT_SEL];
	assign stop_ie = ctrl[CTL_STOP_IE];
	assign ack_en = ctrl[CTL_ACK_EN];
	assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
	assign wr_data = bus_req.wr && (bus_req.addr == OFS_DATA);
	assign start_cmd = wr_ctrl && bus_req.wdata[CTL_START];
	assign stop_cmd = wr_ctrl && bus_req.wdata[CTL_STOP];
	assign wrel_cmd = wr_ctrl && bus_req.wdata[CTL_WREL];
	assign rd_status = bus_req.rd && (bus_req.addr == OFS_STATUS);

	// =====================================================================
	// bus monitor and status flags
	logic busy, addr_phase, ald, exc, trc, ackd, std, spd;
	logic next_busy, next_addr_phase, next_ald, next_exc, next_trc;
	logic next_ackd, next_std, next_spd;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] rx_shift, next_rx_shift, status_word;
	logic [3:0] rx_top;
	logic master, slave_ext, loss_pend, own_stop, waiting, ack_low;
	logic pt8, pt9, data_pt, ev_master, ev_slave, ev_loss, byte_ev;
	logic arb_lost_now, m_start, bit_lost;
	iseq_mstate_t mstate;

	assign status_word = {master, ald, exc, 1'b0, trc, ackd, std, spd};
	assign rx_top = {rx_shift[2:0], sda_line};
	assign pt8 = fall_ev && (bit_cnt == BIT_PT8);
	assign pt9 = fall_ev && (bit_cnt == BIT_PT9);
	assign data_pt = wait_sel ? pt9 : pt8;
	assign ev_master = master && (addr_phase ? pt9 : data_pt);
	assign ev_slave = slave_ext &&
		(addr_phase ? (pt8 || (wait_sel && pt9)) : data_pt);
	assign ev_loss = loss_pend && (addr_phase ? pt9 : data_pt);
	// nothing but the three roles raises a byte event
	assign byte_ev = ev_master || ev_slave || ev_loss;
	assign m_start = (mstate == M_IDLE) && start_cmd && enable && !busy;
	// a foreign stop while mastering also counts as lost arbitration
	assign arb_lost_now = bit_lost ||
		(stop_ev && master && !own_stop);

	always_comb begin
		next_busy = busy;
		next_addr_phase = addr_phase;
		next_bit_cnt = bit_cnt;
		next_rx_shift = rx_shift;
		next_ald = ald;
		next_exc = exc;
		next_trc = trc;
		next_ackd = ackd;
		next_std = std;
		next_spd = spd;
		if (rise_ev && bit_cnt < BIT_PT9)
			next_bit_cnt = 4'(bit_cnt + 4'h1);
		if (rise_ev && bit_cnt < BIT_PT8)
			next_rx_shift = {rx_shift[6:0], sda_line};
		if (rise_ev && bit_cnt == BIT_FIRST) begin
			next_ackd = 1'b0;
			if (!addr_phase)
				next_std = 1'b0;
		end
		if (rise_ev && bit_cnt == BIT_PT8)
			next_ackd = ~sda_line;
		if (rise_ev && addr_phase && bit_cnt == BIT_EXC &&
			(rx_top == EXC_LO || rx_top == EXC_HI))
			next_exc = 1'b1;
		if (rise_ev && addr_phase && bit_cnt == BIT_RW)
			next_trc = master ? ~sda_line : sda_line;
		if (pt9) begin
			next_bit_cnt = BIT_FIRST;
			next_addr_phase = 1'b0;
		end
		if (m_start)
			next_trc = 1'b1;
		if (arb_lost_now)
			next_trc = 1'b0;
		if (start_ev) begin
			next_busy = 1'b1;
			next_addr_phase = 1'b1;
			next_bit_cnt = BIT_FIRST;
			next_exc = 1'b0;
			next_std = 1'b1;
			next_spd = 1'b0;
		end
		if (stop_ev) begin
			next_busy = 1'b0;
			next_exc = 1'b0;
			next_std = 1'b0;
			next_ackd = 1'b0;
			next_trc = 1'b0;
			next_spd = 1'b1;
		end
		// a status read clears the loss flag, a new loss wins over it
		if (rd_status)
			next_ald = 1'b0;
		if (arb_lost_now)
			next_ald = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			busy <= 1'b0;
			addr_phase <= 1'b0;
			bit_cnt <= BIT_FIRST;
			rx_shift <= 8'h00;
			ald <= 1'b0;
			exc <= 1'b0;
			trc <= 1'b0;
			ackd <= 1'b0;
			std <= 1'b0;
			spd <= 1'b0;
		end else begin
			busy <= next_busy;
			addr_phase <= next_addr_phase;
			bit_cnt <= next_bit_cnt;
			rx_shift <= next_rx_shift;
			ald <= next_ald;
			exc <= next_exc;
			trc <= next_trc;
			ackd <= next_ackd;
			std <= next_std;
			spd <= next_spd;
		end
	end

	// =====================================================================
	// master engine: clock, data bits, stop, arbitration
	iseq_mstate_t next_mstate;
	logic [CNT_W-1:0] mcnt, next_mcnt;
	logic [7:0] tx_shift, next_tx_shift;
	logic tx_bit, next_tx_bit, stop_pend, next_stop_pend;
	logic scl_low, next_scl_low, sda_low, next_sda_low;
	logic next_master, next_own_stop;

	// released line read back low while a one is sent
	assign bit_lost = (mstate == M_HIGH) && scl_line && tx_bit &&
		!sda_low && !sda_line;

	always_comb begin
		next_mstate = mstate;
		next_mcnt = mcnt;
		next_tx_shift = tx_shift;
		next_tx_bit = tx_bit;
		next_stop_pend = stop_pend;
		next_scl_low = scl_low;
		next_sda_low = sda_low;
		next_master = master;
		next_own_stop = own_stop;
		if (wr_data && waiting && master)
			next_tx_shift = bus_req.wdata;
		if (stop_cmd && master) begin
			next_stop_pend = 1'b1;
			next_own_stop = 1'b1;
		end
		case (mstate)
			M_IDLE: begin
				if (m_start) begin
					next_master = 1'b1;
					next_tx_shift = tx_byte;
					next_sda_low = 1'b1;
					next_mcnt = '0;
					next_mstate = M_START;
				end
			end
			M_START: begin
				next_mcnt = mcnt + CNT_ONE;
				if (mcnt == HALF_W) begin
					next_scl_low = 1'b1;
					next_mcnt = '0;
					next_mstate = M_LOW;
				end
			end
			M_LOW: begin
				if (!waiting || next_stop_pend)
					next_mcnt = mcnt + CNT_ONE;
				if (mcnt == MID_W) begin
					next_tx_bit = 1'b0;
					next_sda_low = 1'b0;
					// a stop asked in the 8-clock wait still gives the ack clock
					if (stop_pend && bit_cnt != BIT_PT8)
						next_sda_low = 1'b1;
					else if (bit_cnt < BIT_PT8 && (addr_phase || trc)) begin
						next_sda_low = ~tx_shift[~bit_cnt[2:0]];
						next_tx_bit = 1'b1;
					end
				end
				if (mcnt == HALF_W) begin
					next_scl_low = 1'b0;
					next_mcnt = '0;
					next_mstate = (stop_pend && bit_cnt != BIT_PT8) ?
						M_STOP_HIGH : M_HIGH;
				end
			end
			M_HIGH: begin
				if (scl_line)
					next_mcnt = mcnt + CNT_ONE;
				if (mcnt == HALF_W) begin
					next_scl_low = 1'b1;
					next_mcnt = '0;
					next_mstate = M_LOW;
				end
			end
			M_STOP_HIGH: begin
				if (scl_line)
					next_mcnt = mcnt + CNT_ONE;
				if (mcnt == HALF_W) begin
					next_sda_low = 1'b0;
					next_stop_pend = 1'b0;
					next_mcnt = '0;
					next_mstate = M_IDLE;
				end
			end
			default: next_mstate = M_IDLE;
		endcase
		if (arb_lost_now || !enable) begin
			next_master = 1'b0;
			next_scl_low = 1'b0;
			next_sda_low = 1'b0;
			next_tx_bit = 1'b0;
			next_stop_pend = 1'b0;
			next_mcnt = '0;
			next_mstate = M_IDLE;
		end
		if (stop_ev) begin
			next_master = 1'b0;
			next_own_stop = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mstate <= M_IDLE;
			mcnt <= '0;
			tx_shift <= 8'h00;
			tx_bit <= 1'b0;
			stop_pend <= 1'b0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			master <= 1'b0;
			own_stop <= 1'b0;
		end else begin
			mstate <= next_mstate;
			mcnt <= next_mcnt;
			tx_shift <= next_tx_shift;
			tx_bit <= next_tx_bit;
			stop_pend <= next_stop_pend;
			scl_low <= next_scl_low;
			sda_low <= next_sda_low;
			master <= next_master;
			own_stop <= next_own_stop;
		end
	end

	// =====================================================================
	// roles after arbitration, waits and acknowledge
	logic next_slave_ext, next_loss_pend, next_waiting, next_ack_low;
	iseq_pins_t next_pins;

	always_comb begin
		next_slave_ext = slave_ext;
		next_loss_pend = loss_pend;
		next_waiting = waiting;
		next_ack_low = ack_low;
		if (arb_lost_now && !stop_ev) begin
			// an extension code already seen keeps the device as slave
			if (addr_phase && exc)
				next_slave_ext = 1'b1;
			else
				next_loss_pend = 1'b1;
		end
		if (loss_pend && addr_phase && exc) begin
			next_loss_pend = 1'b0;
			next_slave_ext = 1'b1;
		end
		if (ev_loss)
			next_loss_pend = 1'b0;
		if (ev_master || ev_slave)
			next_waiting = 1'b1;
		if (wr_data || wrel_cmd || stop_cmd)
			next_waiting = 1'b0;
		if (pt8 && !trc && ack_en && (slave_ext || (master && !addr_phase)))
			next_ack_low = 1'b1;
		if (pt9)
			next_ack_low = 1'b0;
		if (start_ev || stop_ev || !enable) begin
			next_slave_ext = 1'b0;
			next_loss_pend = 1'b0;
			next_waiting = 1'b0;
			next_ack_low = 1'b0;
		end
		next_pins.scl_out = 1'b0;
		next_pins.sda_out = 1'b0;
		next_pins.scl_oe = next_scl_low || next_waiting;
		next_pins.sda_oe = next_sda_low || next_ack_low;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			slave_ext <= 1'b0;
			loss_pend <= 1'b0;
			waiting <= 1'b0;
			ack_low <= 1'b0;
			pins <= '0;
		end else begin
			slave_ext <= next_slave_ext;
			loss_pend <= next_loss_pend;
			waiting <= next_waiting;
			ack_low <= next_ack_low;
			pins <= next_pins;
		end
	end

	// =====================================================================
	// register file and interrupt
	always_comb begin
		next_ctrl = ctrl;
		next_tx_byte = tx_byte;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_rd_data = 8'h00;
		if (wr_ctrl)
			next_ctrl = bus_req.wdata[3:0];
		if (wr_data)
			next_tx_byte = bus_req.wdata;
		if (bus_req.wr && bus_req.addr == OFS_MASK)
			next_irq_mask = bus_req.wdata[IRQ_W-1:0];
		if (bus_req.wr && bus_req.addr == OFS_IRQ)
			next_irq_stat = irq_stat & ~bus_req.wdata[IRQ_W-1:0];
		// events are applied after the clear so that they win
		if (byte_ev)
			next_irq_stat[IRQ_BYTE] = 1'b1;
		if (stop_ev && stop_ie)
			next_irq_stat[IRQ_STOP] = 1'b1;
		if (bus_req.rd) begin
			case (bus_req.addr)
				OFS_STATUS: next_rd_data = status_word;
				OFS_CTRL: next_rd_data = {4'h0, ctrl};
				OFS_DATA: next_rd_data = rx_shift;
				OFS_IRQ: next_rd_data = {6'h00, irq_stat};
				OFS_MASK: next_rd_data = {6'h00, irq_mask};
				default: next_rd_data = 8'h00;
			endcase
		end
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl <= CTRL_RESET;
			tx_byte <= 8'h00;
			irq_mask <= '0;
			irq_stat <= '0;
			rd_data <= 8'h00;
			bus_event_irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			tx_byte <= next_tx_byte;
			irq_mask <= next_irq_mask;
			irq_stat <= next_irq_stat;
			rd_data <= next_rd_data;
			bus_event_irq <= next_irq;
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence s_ext_addr_ev;
		byte_ev && master && addr_phase && exc && ackd;
	endsequence
	sequence s_held_wait;
		(ev_master || ev_slave) ##1 waiting;
	endsequence

	chk_ext_addr_snap: assert property (
		s_ext_addr_ev |-> (status_word & MASK_X) == SNAP_EXT_ADDR)
		else $error("extension address snapshot wrong");
	chk_ext_data8: assert property (
		byte_ev && master && exc && !addr_phase && !wait_sel |->
		(status_word & MASK_X) == SNAP_EXT_DATA)
		else $error("extension data snapshot wrong at clock 8");
	chk_ext_data9: assert property (
		byte_ev && master && exc && !addr_phase && wait_sel |->
		(status_word & MASK_XX) == SNAP_EXT_DATA && bit_cnt == BIT_PT9)
		else $error("extension data snapshot wrong at clock 9");
	chk_stop_gate: assert property (
		$rose(irq_stat[IRQ_STOP]) |-> $past(stop_ev) && $past(stop_ie))
		else $error("stop interrupt set without enabled stop");
	chk_quiet_bus: assert property (
		byte_ev |-> master || slave_ext || loss_pend)
		else $error("byte event while not involved");
	chk_ext_loss: assert property (
		arb_lost_now && !stop_ev && addr_phase && exc |=>
		ald && slave_ext && !master)
		else $error("extension loss did not continue as slave");
	chk_loss_data8: assert property (
		ev_loss && !addr_phase && !wait_sel |->
		(status_word & MASK_ALL) == SNAP_LOSS8 ##1 !loss_pend)
		else $error("loss snapshot wrong at clock 8");
	chk_loss_data9: assert property (
		ev_loss && !addr_phase && wait_sel && ackd |->
		(status_word & MASK_ALL) == SNAP_LOSS9)
		else $error("loss snapshot wrong at clock 9");
	chk_foreign_stop: assert property (
		stop_ev && master && !own_stop |=> ald && spd && !master)
		else $error("foreign stop not taken as loss");
	chk_stop_flag: assert property (
		stop_ev |=> spd && !busy)
		else $error("stop flag not set");
	chk_master_addr9: assert property (
		byte_ev && master && addr_phase |-> bit_cnt == BIT_PT9)
		else $error("master address event not on clock 9");
	chk_wait_hold: assert property (
		s_held_wait |=> pins.scl_oe)
		else $error("wait does not hold the clock low");
endmodule

// ### verification/iseq_bus_model.sv
// far side of the bus: acking slave, competing master, foreign stop
`timescale 1ns/100ps
module iseq_bus_model #(
	parameter int H_NS = 64
) (
	// resolved lines
	input wire logic scl,
	input wire logic sda,
	// behaviour select
	input wire logic ack_on,
	input wire logic [7:0] lose_at,
	// open-drain drives
	output logic scl_oe,
	output logic sda_oe
);
	// =====================================================================
	// fall count since the last start; byte b bit k is placed after 9b+k
	int n;
	initial begin
		n = 0;
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	always @(negedge sda) begin
		if (scl) begin
			n = -1;
		end
	end
	always @(negedge scl) begin
		n = n + 1;
		// ack in the ninth low phase, or a zero against a sent one
		sda_oe = (ack_on && n % 9 == 8) || n == int'(lose_at);
	end
	// =====================================================================
	// after winning, finish the byte on our own clock, then stop
	always begin
		wait (n == int'(lose_at));
		@(posedge scl);
		#(H_NS);
		repeat (8 - int'(lose_at) % 9) begin
			scl_oe = 1'b1;
			#(H_NS);
			scl_oe = 1'b0;
			#(H_NS);
		end
		scl_oe = 1'b1;
		#(H_NS);
		sda_oe = 1'b1;
		#(H_NS);
		scl_oe = 1'b0;
		#(H_NS);
		sda_oe = 1'b0;
	end
	// let the acknowledge go in the middle of its high phase: a stop
	task automatic drop_ack();
		@(posedge scl);
		#(H_NS / 2);
		sda_oe = 1'b0;
	endtask
	// start then stop with no byte, traffic that never names the device
	task automatic pulse();
		sda_oe = 1'b1;
		#(H_NS);
		sda_oe = 1'b0;
	endtask
endmodule

// ### verification/iseq_top_tb_top.sv
// self-checking bench: registers, master transfers, arbitration loss
`timescale 1ns/100ps
module iseq_top_tb_top;
	import iseq_pkg::*;
	logic clk_sys;
	logic srst;
	iseq_bus_req_t bus_req;
	logic [7:0] rd_data;
	logic bus_event_irq;
	iseq_pins_t pins;
	logic m_scl_oe;
	logic m_sda_oe;
	logic ack_on;
	logic [7:0] lose_at;
	logic [7:0] s;
	int error_cnt;
	int tests_run;
	// open-drain lines with pull-ups
	wire logic scl = !(pins.scl_oe || m_scl_oe);
	wire logic sda = !(pins.sda_oe || m_sda_oe);

	iseq_top #(.HALF_CYC(16)) iseq_top_i (.clk_sys(clk_sys), .srst(srst),
		.bus_req(bus_req), .rd_data(rd_data), .bus_event_irq(bus_event_irq),
		.scl_in(scl), .data_line_pin(sda), .pins(pins));
	iseq_bus_model iseq_bus_model_i (.scl(scl), .sda(sda), .ack_on(ack_on),
		.lose_at(lose_at), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// =====================================================================
	// access and compare tasks
	task automatic finish_test();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req <= '0;
		#1;
		d = rd_data;
	endtask
	// wait for the interrupt, compare the masked status, clear the event
	task automatic ev(input logic [7:0] m, input logic [7:0] e,
		input logic [7:0] clr);
		int i;
		for (i = 0; i < 5000 && bus_event_irq !== 1'b1; i++) begin
			@(posedge clk_sys);
		end
		if (bus_event_irq !== 1'b1) begin
			error_cnt++;
			finish_test();
		end
		rd(OFS_STATUS, s);
		chk(s & m, e);
		wr(OFS_IRQ, clr);
		repeat (4) @(posedge clk_sys);
	endtask

	// =====================================================================
	// scenarios
	task automatic xfer(input logic sel);
		logic [7:0] cfg;
		cfg = {5'h00, 1'b1, sel, 1'b1};
		wr(OFS_DATA, 8'h08);
		wr(OFS_CTRL, cfg | 8'h10);
		rd(OFS_CTRL, s);
		chk(s, cfg);
		ev(8'hf7, 8'ha6, 8'h01);
		wr(OFS_DATA, 8'h5a);
		ev(8'hf7, sel ? 8'ha4 : 8'ha0, 8'h01);
		wr(OFS_DATA, 8'h3c);
		ev(8'hf3, 8'ha0, 8'h01);
		wr(OFS_CTRL, cfg | 8'h20);
		ev(8'hff, 8'h01, 8'h02);
	endtask
	task automatic loss(input logic sel);
		lose_at = 8'd11;
		wr(OFS_DATA, 8'ha0);
		wr(OFS_CTRL, {5'h02, 1'b1, sel, 1'b1});
		ev(8'hff, 8'h8e, 8'h01);
		wr(OFS_DATA, 8'hff);
		ev(8'hff, sel ? 8'h44 : 8'h40, 8'h01);
		ev(8'hff, 8'h01, 8'h02);
		lose_at = 8'hff;
	endtask

	initial begin
		srst = 1'b1;
		bus_req = '0;
		ack_on = 1'b1;
		lose_at = 8'hff;
		error_cnt = 0;
		tests_run = 0;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		rd(OFS_STATUS, s);
		chk(s, 8'h00);
		rd(OFS_CTRL, s);
		chk(s, 8'h00);
		rd(3'h7, s);
		chk(s, 8'h00);
		// foreign traffic, stop interrupt disabled, then enabled but masked
		wr(OFS_CTRL, 8'h01);
		iseq_bus_model_i.pulse();
		repeat (40) @(posedge clk_sys);
		rd(OFS_IRQ, s);
		chk(s, 8'h00);
		wr(OFS_MASK, 8'h01);
		wr(OFS_CTRL, 8'h05);
		iseq_bus_model_i.pulse();
		repeat (40) @(posedge clk_sys);
		chk({7'h00, bus_event_irq}, 8'h00);
		rd(OFS_IRQ, s);
		chk(s, 8'h02);
		wr(OFS_MASK, 8'h03);
		ev(8'hff, 8'h01, 8'h02);
		chk({7'h00, bus_event_irq}, 8'h00);
		xfer(1'b0);
		xfer(1'b1);
		loss(1'b0);
		loss(1'b1);
		// extension code lost at its fifth bit, continuing as slave
		lose_at = 8'd4;
		wr(OFS_DATA, 8'h08);
		wr(OFS_CTRL, 8'h15);
		ev(8'hf7, 8'h62, 8'h01);
		wr(OFS_CTRL, 8'h45);
		ev(8'hff, 8'h01, 8'h02);
		lose_at = 8'hff;
		// foreign stop made by ending the acknowledge early
		wr(OFS_DATA, 8'ha0);
		wr(OFS_CTRL, 8'h15);
		ev(8'hf7, 8'h86, 8'h01);
		wr(OFS_DATA, 8'h00);
		ev(8'hff, 8'h88, 8'h01);
		wr(OFS_DATA, 8'h00);
		iseq_bus_model_i.drop_ack();
		ev(8'hff, 8'h41, 8'h02);
		finish_test();
	end
endmodule
